//--- rtl/pafs_pkg.sv
/*
 * Package for the port A upper pin function select block: register offset,
 * field positions, reset pattern and the pin carrier structs.
 * Assumes an APB master with 32-bit data and one aligned word per register.
 */
package pafs_pkg;

   // *****************************************************************
   // Register map
   // *****************************************************************
   localparam logic [11:0] PAFS_SEL_OFFSET   = 12'h00c;
   localparam logic [15:0] PAFS_SEL_RESET    = 16'h4000;
   localparam logic [15:0] PAFS_SEL_WMASK    = 16'h515a;

   // *****************************************************************
   // Field positions
   // *****************************************************************
   localparam int PIN15_FUNCTION_BIT = 14;
   localparam int PIN14_FUNCTION_BIT = 12;
   localparam int PIN12_FUNCTION_BIT = 8;
   localparam int PIN11_FUNCTION_BIT = 6;
   localparam int PIN10_FUNCTION_BIT = 4;
   localparam int PIN9_FUNCTION_BIT  = 3;
   localparam int PIN8_FUNCTION_BIT  = 1;

   // Pin order in the carriers: 0 pin8, 1 pin9, 2 pin10, 3 pin11, 4 pin12, 5 pin14, 6 pin15.
   localparam int PAFS_NPINS = 7;

   typedef struct packed {
      logic [PAFS_NPINS-1:0] out;
      logic [PAFS_NPINS-1:0] oe;
   } pafs_drive_type;

   typedef struct packed {
      logic system_clock_output;
      logic read_strobe;
      logic low_byte_write_strobe;
      logic chip_select_one;
      logic chip_select_zero;
   } pafs_alt_out_type;

   typedef struct packed {
      logic interrupt_request_three;
      logic interrupt_request_two;
   } pafs_irq_in_type;

endpackage

//--- rtl/pafs_top.sv
/*
 * Port A upper pin function select: one APB register whose bits hand each
 * of pins 15, 14, 12, 11, 10, 9 and 8 to the general port or to an
 * alternative unit. Assumes pad inputs arrive asynchronous and that rst_n
 * is the external power-on reset only.
 */
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
module pafs_top
   import pafs_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   input  wire pafs_drive_type        gpio_drive,
   output pafs_drive_type             pad_drive,
   input  wire logic [PAFS_NPINS-1:0] pad_in,
   output logic [PAFS_NPINS-1:0]      gpio_in,
   input  wire pafs_alt_out_type      alt_out,
   output pafs_irq_in_type            irq_in,
   output logic [15:0]                function_select
);

   // *****************************************************************
   // Reset release and pad synchronisers
   // *****************************************************************
   logic [1:0]            rst_sync_q;
   logic [1:0]            rst_sync_d;
   logic                  rst_int_n;
   logic [PAFS_NPINS-1:0] pad_meta_q;
   logic [PAFS_NPINS-1:0] pad_meta_d;
   logic [PAFS_NPINS-1:0] pad_sync_q;
   logic [PAFS_NPINS-1:0] pad_sync_d;

   // The release ripples through two stages, so no register sees rst_n rise close to a clock edge.
   always_comb
   begin
      rst_sync_d = {rst_sync_q[0], 1'b1};
   end

   // Pads are asynchronous; only the second stage is read, since the first may still be settling.
   always_comb
   begin
      pad_meta_d = pad_in;
      pad_sync_d = pad_meta_q;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_sync_q <= 2'h0;
      end
      else
      begin
         rst_sync_q <= rst_sync_d;
      end
   end
   assign rst_int_n = rst_sync_q[1];

   always_ff @(posedge clk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         pad_meta_q <= '0;
         pad_sync_q <= '0;
      end
      else
      begin
         pad_meta_q <= pad_meta_d;
         pad_sync_q <= pad_sync_d;
      end
   end

   // *****************************************************************
   // Register
   // *****************************************************************
   logic [15:0] sel_q;
   logic [15:0] sel_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        hit;
   logic        wr_en;

   function automatic logic [15:0] merge_lanes(input logic [15:0] old_v,
                                                input logic [31:0] wd,
                                                input logic [3:0]  st);
      logic [15:0] r;
      r = old_v;
      if (st[0])
      begin
         r[7:0] = wd[7:0];
      end
      if (st[1])
      begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   assign hit   = (paddr[11:2] == PAFS_SEL_OFFSET[11:2]);
   assign wr_en = psel && penable && pwrite && hit;

   always_comb
   begin
      sel_d = sel_q;
      if (wr_en)
      begin
         // Reserved positions are masked so they stay zero.
         sel_d = merge_lanes(sel_q, pwdata, pstrb) & PAFS_SEL_WMASK;
      end
      rdata_d = rdata_q;
      if (psel && !penable && !pwrite)
      begin
         rdata_d = hit ? {16'h0000, sel_q} : 32'h0000_0000;
      end
   end

   // Only rst_n, the power-on reset, restores the pattern; there is no other reset input.
   always_ff @(posedge clk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         sel_q   <= PAFS_SEL_RESET;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         sel_q   <= sel_d;
         rdata_q <= rdata_d;
      end
   end

   // The register answers in the first access cycle, so no wait state is ever inserted.
   // Read data is sampled in the setup cycle; that keeps prdata on a flip-flop, and it is
   // safe because no write can land between the setup and the access of a read.
   assign pready          = 1'b1;
   assign pslverr         = psel && penable && !hit;
   assign prdata          = rdata_q;
   assign function_select = sel_q;

   // *****************************************************************
   // Pin multiplexing
   // *****************************************************************
   logic [PAFS_NPINS-1:0] alt_sel;
   logic [PAFS_NPINS-1:0] alt_val;
   logic [PAFS_NPINS-1:0] alt_oe;

   // Maps a carrier index to the select bit that owns that pin; the mux and the
   // ownership checks both decode through it, so they cannot drift apart.
   function automatic int pin_field(input int idx);
      int f;
      case (idx)
         0: f = PIN8_FUNCTION_BIT;
         1: f = PIN9_FUNCTION_BIT;
         2: f = PIN10_FUNCTION_BIT;
         3: f = PIN11_FUNCTION_BIT;
         4: f = PIN12_FUNCTION_BIT;
         5: f = PIN14_FUNCTION_BIT;
         6: f = PIN15_FUNCTION_BIT;
         default: f = PIN15_FUNCTION_BIT;
      endcase
      return f;
   endfunction
   assign alt_val = {alt_out.system_clock_output, alt_out.read_strobe, alt_out.low_byte_write_strobe,
                     alt_out.chip_select_one, alt_out.chip_select_zero, 2'b00};
   // Interrupt pins become inputs, so the pad driver is off in that mode.
   assign alt_oe  = 7'h7c;

   generate
      for (genvar i = 0; i < PAFS_NPINS; i++)
      begin : g_pin
         assign alt_sel[i] = sel_q[pin_field(i)];
         // A clear bit gives the pad wholly to the port; the alternative is cut off.
         assign pad_drive.out[i] = alt_sel[i] ? alt_val[i] : gpio_drive.out[i];
         assign pad_drive.oe[i]  = alt_sel[i] ? alt_oe[i] : gpio_drive.oe[i];
         assign gpio_in[i]       = alt_sel[i] ? 1'b0 : pad_sync_q[i];
      end
   endgenerate

   // Interrupt inputs idle high (inactive low requests) when not selected.
   assign irq_in.interrupt_request_three = sel_q[PIN9_FUNCTION_BIT] ? pad_sync_q[1] : 1'b1;
   assign irq_in.interrupt_request_two   = sel_q[PIN8_FUNCTION_BIT] ? pad_sync_q[0] : 1'b1;

   // *****************************************************************
   // Checks
   // *****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_int_n);

   a_reserved_zero: assert property (function_select[15] == 1'b0 && function_select[13] == 1'b0 &&
      function_select[11:9] == 3'h0 && function_select[7] == 1'b0 && function_select[5] == 1'b0 &&
      function_select[2] == 1'b0 && function_select[0] == 1'b0)
      else $error("reserved bit set");
   a_write_takes: assert property (wr_en && pstrb[1] |=> function_select[14] == $past(pwdata[14]))
      else $error("pin15 select not written");
   a_pin15_clock: assert property (function_select[14] |-> pad_drive.out[6] == alt_out.system_clock_output)
      else $error("pin15 not clock");
   a_pin14_read: assert property (function_select[12] |-> pad_drive.out[5] == alt_out.read_strobe)
      else $error("pin14 not read strobe");
   a_pin12_wrl: assert property (function_select[8] |-> pad_drive.out[4] == alt_out.low_byte_write_strobe)
      else $error("pin12 not write strobe");
   a_pin11_cs1: assert property (function_select[6] |-> pad_drive.out[3] == alt_out.chip_select_one)
      else $error("pin11 not cs1");
   a_pin10_cs0: assert property (function_select[4] |-> pad_drive.out[2] == alt_out.chip_select_zero)
      else $error("pin10 not cs0");
   a_pin9_irq: assert property (function_select[3] |-> irq_in.interrupt_request_three == pad_sync_q[1])
      else $error("pin9 irq not routed");
   a_pin8_irq: assert property (function_select[1] |-> !pad_drive.oe[0] && !gpio_in[0])
      else $error("pin8 not input");
   a_gpio_owns: assert property (!function_select[4] |-> pad_drive.out[2] == gpio_drive.out[2] &&
      pad_drive.oe[2] == gpio_drive.oe[2])
      else $error("gpio lost pin10");
   a_hold_value: assert property (!wr_en |=> $stable(function_select))
      else $error("register changed without write");

   // *****************************************************************
   // Bus checks
   // *****************************************************************
   // Lane checks follow the byte strobes; the two upper lanes hold no register bits.
   a_low_lane: assert property (wr_en && pstrb[0] |=>
      function_select[7:0] == ($past(pwdata[7:0]) & PAFS_SEL_WMASK[7:0]))
      else $error("low lane not written");
   a_high_lane: assert property (wr_en && pstrb[1] |=>
      function_select[15:8] == ($past(pwdata[15:8]) & PAFS_SEL_WMASK[15:8]))
      else $error("high lane not written");
   a_low_kept: assert property (wr_en && !pstrb[0] |=> $stable(function_select[7:0]))
      else $error("low lane changed without strobe");
   a_high_kept: assert property (wr_en && !pstrb[1] |=> $stable(function_select[15:8]))
      else $error("high lane changed without strobe");
   a_read_data: assert property (psel && !penable && !pwrite && hit |=>
      prdata == {16'h0000, $past(function_select)})
      else $error("read data not register value");
   a_read_miss: assert property (psel && !penable && !pwrite && !hit |=> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_write_miss: assert property (psel && penable && pwrite && !hit |=> $stable(function_select))
      else $error("unmapped write changed register");
   a_err_mapped: assert property (psel && penable && hit |-> !pslverr)
      else $error("error on mapped access");
   a_reset_pattern: assert property ($rose(rst_int_n) |-> function_select == PAFS_SEL_RESET)
      else $error("register not at reset pattern");

   // *****************************************************************
   // Pin checks
   // *****************************************************************
   // Interrupt pins are inputs, so only the five output functions need the driver on.
   a_pin15_oe: assert property (function_select[14] |-> pad_drive.oe[6])
      else $error("pin15 driver off");
   a_pin14_oe: assert property (function_select[12] |-> pad_drive.oe[5])
      else $error("pin14 driver off");
   a_pin12_oe: assert property (function_select[8] |-> pad_drive.oe[4])
      else $error("pin12 driver off");
   a_pin11_oe: assert property (function_select[6] |-> pad_drive.oe[3])
      else $error("pin11 driver off");
   a_pin10_oe: assert property (function_select[4] |-> pad_drive.oe[2])
      else $error("pin10 driver off");
   a_pin9_input: assert property (function_select[3] |-> !pad_drive.oe[1] && !gpio_in[1])
      else $error("pin9 not input");
   a_pin8_route: assert property (function_select[1] |-> irq_in.interrupt_request_two == pad_sync_q[0])
      else $error("pin8 irq not routed");
   a_irq_idle: assert property ((function_select[3] || irq_in.interrupt_request_three) &&
      (function_select[1] || irq_in.interrupt_request_two))
      else $error("unselected irq not idle");

   // Every pin is checked against the register output, one carrier index at a time.
   generate
      for (genvar j = 0; j < PAFS_NPINS; j++)
      begin : g_pin_check
         a_port_owns_pin: assert property (!function_select[pin_field(j)] |->
            pad_drive.out[j] == gpio_drive.out[j] && pad_drive.oe[j] == gpio_drive.oe[j] &&
            gpio_in[j] == pad_sync_q[j])
            else $error("port lost a pin");
         a_alt_cuts_port: assert property (function_select[pin_field(j)] |-> !gpio_in[j])
            else $error("port sees a pin given away");
      end
   endgenerate

   // *****************************************************************
   // Coverage
   // *****************************************************************
   c_write: cover property (wr_en ##1 function_select[12]);
   c_read: cover property (psel && penable && !pwrite && hit && prdata[14]);
   c_clock_off: cover property (!function_select[14]);
   c_bad_addr: cover property (pslverr);
   c_irq_pins: cover property (function_select[3] && function_select[1]);

endmodule

//--- dv/tb.sv
/*
 * Self-checking bench for the port A pin function select block.
 * Assumes the slave answers in its own time and pads settle within 3 cycles.
 */
`timescale 1ns/100ps
module tb
   import pafs_pkg::*;
;
   logic             clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0]      paddr;
   logic [31:0]      pwdata, prdata;
   logic [3:0]       pstrb;
   pafs_drive_type   gpio_drive, pad_drive;
   logic [6:0]       pad_in, gpio_in;
   pafs_alt_out_type alt_out;
   pafs_irq_in_type  irq_in;
   logic [15:0]      function_select, r;
   logic [33:0]      exp_q[$];
   logic [33:0]      e;
   int               n_fail, checked, seed;

   pafs_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .gpio_drive(gpio_drive), .pad_drive(pad_drive), .pad_in(pad_in),
      .gpio_in(gpio_in), .alt_out(alt_out), .irq_in(irq_in), .function_select(function_select));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      checked++;
      if (g !== x)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask

   task automatic finish_test();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // A model write applies only the writable bits of the enabled low lanes.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic        hit;
      logic [15:0] m;
      hit = (a[11:2] == PAFS_SEL_OFFSET[11:2]);
      m = {{8{s[1]}}, {8{s[0]}}} & PAFS_SEL_WMASK;
      exp_q.push_back({w, ~hit, (hit && !w) ? {16'h0000, r} : 32'h0000_0000});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      if (w && hit)
         r = (r & ~m) | (d[15:0] & m);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   always @(posedge clk)
      if (psel && penable && pready === 1'b1)
      begin
         e = exp_q.pop_front();
         cmp({31'h0, pslverr}, {31'h0, e[32]});
         if (!e[33])
            cmp(prdata, e[31:0]);
      end

   // Irq pins are inputs when selected, so their output level is masked.
   task automatic chk_pins();
      logic [6:0] sel, ao, eo, eoe, m;
      sel = {r[PIN15_FUNCTION_BIT], r[PIN14_FUNCTION_BIT], r[PIN12_FUNCTION_BIT], r[PIN11_FUNCTION_BIT],
             r[PIN10_FUNCTION_BIT], r[PIN9_FUNCTION_BIT], r[PIN8_FUNCTION_BIT]};
      ao = {alt_out, 2'b00};
      eo = (sel & ao) | (~sel & gpio_drive.out);
      eoe = (sel & 7'h7c) | (~sel & gpio_drive.oe);
      m = ~(sel & 7'h03);
      cmp({16'h0, function_select}, {16'h0, r});
      cmp({25'h0, pad_drive.out & m}, {25'h0, eo & m});
      cmp({25'h0, pad_drive.oe}, {25'h0, eoe});
      cmp({25'h0, gpio_in}, {25'h0, ~sel & pad_in});
      cmp({30'h0, irq_in}, {30'h0, sel[1] ? pad_in[1] : 1'b1, sel[0] ? pad_in[0] : 1'b1});
   endtask

   task automatic do_reset();
      rst_n <= 1'b0;
      r = PAFS_SEL_RESET;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask

   initial
   begin
      #(2000 * 50);
      n_fail++;
      finish_test();
   end

   initial
   begin
      seed = 32'h5a28;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {gpio_drive, pad_in, alt_out} = '0;
      n_fail = 0;
      checked = 0;
      rst_n = 1'b0;
      do_reset();
      xfer(1'b0, PAFS_SEL_OFFSET, 32'h0, 4'h0);
      #1 chk_pins();
      @(posedge clk);
      $display("Test reset values done");
      xfer(1'b1, PAFS_SEL_OFFSET, 32'hffff_ffff, 4'hf);
      xfer(1'b0, PAFS_SEL_OFFSET, 32'h0, 4'h0);
      xfer(1'b1, PAFS_SEL_OFFSET, 32'h0, 4'h1);
      xfer(1'b0, PAFS_SEL_OFFSET, 32'h0, 4'h0);
      xfer(1'b1, 12'h010, 32'hffff_ffff, 4'hf);
      xfer(1'b0, 12'h010, 32'h0, 4'h0);
      xfer(1'b0, PAFS_SEL_OFFSET, 32'h0, 4'h0);
      $display("Test reserved bits and strobes done");
      for (int i = 0; i < 24; i++)
      begin
         gpio_drive <= 14'($random(seed));
         alt_out <= 5'($random(seed));
         pad_in <= 7'($random(seed));
         xfer(1'b1, PAFS_SEL_OFFSET, i == 0 ? 32'h515a : i == 1 ? 32'h0 : $random(seed),
              i < 2 ? 4'hf : 4'($random(seed)));
         xfer(1'b0, PAFS_SEL_OFFSET, 32'h0, 4'h0);
         repeat (2) @(posedge clk);
         #1 chk_pins();
         @(posedge clk);
      end
      $display("Test pin routing done");
      xfer(1'b1, PAFS_SEL_OFFSET, 32'h0, 4'hf);
      do_reset();
      xfer(1'b0, PAFS_SEL_OFFSET, 32'h0, 4'h0);
      #1 chk_pins();
      $display("Test second reset done");
      finish_test();
   end
endmodule
